// ---- feg_pkg.sv ----
/*
 Shared constants, register layouts and types for the tone contour generator.
 Assumes one 10 MHz system clock and an AXI4-Lite register master.
*/
package feg_pkg;
    // Clock and envelope tick timing
    localparam int FEG_CLK_NS = 100;
    localparam int FEG_TICK_NS = 1000000;
    localparam int FEG_TICK_CYC = (FEG_TICK_NS + FEG_CLK_NS - 1) / FEG_CLK_NS;

    // Parameter encodings
    localparam logic [6:0] PAR_ZERO = 7'h00;
    localparam logic [6:0] PAR_MAX = 7'h63;
    localparam logic [6:0] PAR_HOLD = 7'h64;

    // Level scale: full level is 99 sustain units
    localparam logic [15:0] LVL_ZERO = 16'h0000;
    localparam logic [15:0] LVL_MAX = 16'hff3c;
    localparam logic [15:0] SUS_UNIT = 16'h0294;
    localparam logic [12:0] DLY_UNIT = 13'h0032;

    // Key tracking: timing doubles or halves over two octaves
    localparam logic [6:0] KEY_CENTER = 7'h3c;
    localparam int TRK_SPAN = 24;

    // Output scaling
    localparam logic [6:0] VEL_FULL = 7'h7f;
    localparam logic [13:0] VEL_SPAN = 14'h311d;
    localparam logic [36:0] OUT_DIV = 37'h00012fe37;

    // Register map (byte addresses)
    localparam logic [7:0] ADDR_TIME0 = 8'h00;
    localparam logic [7:0] ADDR_TIME1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [31:0] TIME_MASK = 32'h7f7f7f7f;
    localparam logic [31:0] CTRL_MASK = 32'h0000ff3f;
    localparam logic [31:0] TIME0_RST = 32'h63000000;
    localparam logic [31:0] TIME1_RST = 32'h00630000;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic rsv3;
        logic [6:0] sdecay;
        logic rsv2;
        logic [6:0] sustain;
        logic rsv1;
        logic [6:0] decay;
        logic rsv0;
        logic [6:0] attack;
    } feg_time0_t;

    typedef struct packed {
        logic rsv3;
        logic [6:0] velmod;
        logic rsv2;
        logic [6:0] level;
        logic rsv1;
        logic [6:0] delay;
        logic rsv0;
        logic [6:0] release_t;
    } feg_time1_t;

    typedef struct packed {
        logic [15:0] rsv_hi;
        logic [7:0] depth;
        logic [1:0] rsv_lo;
        logic mod_src;
        logic mono;
        logic pedal_en;
        logic track;
        logic trig_reset;
        logic trig_free;
    } feg_ctrl_t;

    typedef struct packed {
        logic on;
        logic off;
        logic legato;
        logic [6:0] vel;
        logic [6:0] key;
    } feg_note_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DELAY = 6'h02,
        ST_ATTACK = 6'h04,
        ST_DECAY = 6'h08,
        ST_SUST = 6'h10,
        ST_RELEASE = 6'h20
    } feg_stage_t;
endpackage

// ---- feg_tone_contour_gen.sv ----
/*
 Tone contour generator: delay, attack, decay, sustain decay and release envelope
 for one voice layer, with an AXI4-Lite register slave and a scaled cutoff output.
 Assumes note and pedal inputs synchronous to aclk; note on and off are one-cycle pulses.
*/
// Functional notes
// - Output zero unless depth nonzero or routed
// - Attack time sets rise; zero rises instantly
// - After peak, fall toward sustain over decay
// - Sustain 99 skips decay entirely
// - Sustain decay falls to zero; 99 holds
// - Release falls level to zero over release
// - Delay waits before attack; zero skips it
// - Delay hold waits for key release
// - Delay hold forces run-to-completion
// - Normal mode: new note restarts only in release
// - Normal mode: note-off jumps to release
// - Run mode completes whole sequence
// - Reset mode restarts on every note
// - Reset-run restarts and completes sequence
// - Mono legato retriggers only in reset modes
// - Key tracking scales all but delay and attack
// - Pedal option makes pedal hold notes
// - Instant envelope plus pedal: note-off releases
// - Pedal note-off in attack jumps sustain
// - Pedal note-off in delay keeps zero
// - Level setting scales whole output
// - Velocity modulation scales output by velocity
`timescale 1ns/1ns
module feg_tone_contour_gen
    import feg_pkg::*;
#(
    parameter int TICK_CYCLES = FEG_TICK_CYC
) (
    input logic aclk,
    input logic aresetn,
    input logic ce,
    input logic [7:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [7:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input feg_note_t note,
    input logic pedal,
    output logic [15:0] mod_level
);
    feg_time0_t t0_q;
    feg_time1_t t1_q;
    feg_ctrl_t ctl_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] m_t0;
    logic [31:0] m_t1;
    logic [31:0] m_ctl;
    feg_stage_t stage_q, stage_d;
    logic [15:0] level_q, level_d;
    logic [12:0] dcnt_q, dcnt_d;
    logic [15:0] tcnt_q;
    logic tick_q;
    logic held_q;
    logic gate_q;
    logic [6:0] vel_q;
    logic [6:0] key_q;

    function automatic logic [6:0] clamp99(input logic [6:0] v);
        return (v > PAR_MAX) ? PAR_MAX : v;
    endfunction

    // Quadratic curve gives long times fine control at the slow end
    function automatic logic [16:0] base_step(input logic [6:0] t);
        logic [16:0] inv;
        inv = {10'h000, PAR_HOLD - clamp99(t)};
        return inv * inv;
    endfunction

    function automatic logic [16:0] trk_step(input logic [16:0] s, input logic [6:0] key);
        int d;
        int r;
        d = int'(key) - int'(KEY_CENTER);
        if (d > TRK_SPAN) d = TRK_SPAN;
        if (d < -TRK_SPAN) d = -TRK_SPAN;
        if (d >= 0) r = int'(s) * (TRK_SPAN + d) / TRK_SPAN;
        else r = int'(s) * (2 * TRK_SPAN + d) / (2 * TRK_SPAN);
        return 17'(r);
    endfunction

    // Register bus decode
    wire wr_fire = !awready && !wready && !bvalid;
    wire w_t0 = waddr_q == ADDR_TIME0;
    wire w_t1 = waddr_q == ADDR_TIME1;
    wire w_ctl = waddr_q == ADDR_CTRL;
    wire w_ok = w_t0 || w_t1 || w_ctl || (waddr_q == ADDR_STAT);
    wire r_ok = (araddr == ADDR_TIME0) || (araddr == ADDR_TIME1) || (araddr == ADDR_CTRL)
        || (araddr == ADDR_STAT);
    wire [31:0] stat_word = {level_q, 10'h000, stage_q};
    wire [31:0] rd_word = (araddr == ADDR_TIME0) ? t0_q :
        (araddr == ADDR_TIME1) ? t1_q :
        (araddr == ADDR_CTRL) ? ctl_q :
        (araddr == ADDR_STAT) ? stat_word : 32'h00000000;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign m_t0[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : t0_q[8*i +: 8];
        assign m_t1[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : t1_q[8*i +: 8];
        assign m_ctl[8*i +: 8] = wstrb_q[i] ? wdata_q[8*i +: 8] : ctl_q[8*i +: 8];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            waddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                waddr_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Reserved bits are masked so they always read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t0_q <= TIME0_RST;
            t1_q <= TIME1_RST;
            ctl_q <= CTRL_RST;
        end else if (ce && wr_fire) begin
            if (w_t0) t0_q <= m_t0 & TIME_MASK;
            if (w_t1) t1_q <= m_t1 & TIME_MASK;
            if (w_ctl) ctl_q <= m_ctl & CTRL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Note gating
    wire hold_dly = t1_q.delay > PAR_MAX;
    wire frun = ctl_q.trig_free || hold_dly;
    wire held_d = note.on || (held_q && !note.off);
    wire gate_d = held_d || (ctl_q.pedal_en && pedal);
    wire rel_ev = gate_q && !gate_d;
    wire pedal_hold_ev = note.off && !note.on && held_q && ctl_q.pedal_en && pedal;
    wire quick = (t1_q.delay == PAR_ZERO) && (t0_q.attack == PAR_ZERO)
        && ((t0_q.decay == PAR_ZERO) || (t0_q.sustain == PAR_MAX));
    wire legato_hold = ctl_q.mono && note.legato && !ctl_q.trig_reset;
    wire retrig = note.on && ((stage_q == ST_IDLE) || ctl_q.trig_reset
        || ((stage_q == ST_RELEASE) && !legato_hold));
    wire no_ovr = !retrig && !pedal_hold_ev && !(rel_ev && !frun);

    // Stage rates; attack is never key tracked
    wire [16:0] step_a = base_step(t0_q.attack);
    wire [16:0] raw_d = base_step(t0_q.decay);
    wire [16:0] raw_s = base_step(t0_q.sdecay);
    wire [16:0] raw_r = base_step(t1_q.release_t);
    wire [16:0] step_d = ctl_q.track ? trk_step(raw_d, key_q) : raw_d;
    wire [16:0] step_s = ctl_q.track ? trk_step(raw_s, key_q) : raw_s;
    wire [16:0] step_r = ctl_q.track ? trk_step(raw_r, key_q) : raw_r;
    wire [17:0] lvl_up = {2'b00, level_q} + {1'b0, step_a};
    wire [15:0] sus_lvl = 16'({9'h000, clamp99(t0_q.sustain)} * SUS_UNIT);
    wire [15:0] over_sus = level_q - sus_lvl;
    wire [15:0] start_lvl = ((t1_q.delay == PAR_ZERO) && (t0_q.attack == PAR_ZERO)) ? LVL_MAX :
        (ctl_q.trig_reset ? LVL_ZERO : level_q);
    wire [12:0] dly_load = 13'({6'h00, t1_q.delay} * DLY_UNIT);

    always_comb begin
        stage_d = stage_q;
        level_d = level_q;
        dcnt_d = dcnt_q;
        unique case (stage_q)
            ST_IDLE: begin
                level_d = level_q;
            end
            ST_DELAY: begin
                if (hold_dly) begin
                    if (!gate_d) stage_d = ST_ATTACK;
                end else if (dcnt_q == 13'h0000) begin
                    stage_d = ST_ATTACK;
                end else if (tick_q) begin
                    dcnt_d = dcnt_q - 13'h0001;
                end
            end
            ST_ATTACK: begin
                if ((t0_q.attack == PAR_ZERO) || (tick_q && (lvl_up >= {2'b00, LVL_MAX}))) begin
                    level_d = LVL_MAX;
                    stage_d = (t0_q.sustain >= PAR_MAX) ? ST_SUST : ST_DECAY;
                end else if (tick_q) begin
                    level_d = lvl_up[15:0];
                end
            end
            ST_DECAY: begin
                if ((t0_q.decay == PAR_ZERO) || (level_q <= sus_lvl)
                        || (tick_q && ({1'b0, over_sus} <= step_d))) begin
                    level_d = sus_lvl;
                    stage_d = ST_SUST;
                end else if (tick_q) begin
                    level_d = level_q - step_d[15:0];
                end
            end
            ST_SUST: begin
                if (frun && !gate_d) begin
                    stage_d = ST_RELEASE;
                end else if (t0_q.sdecay >= PAR_MAX) begin
                    level_d = level_q;
                end else if (t0_q.sdecay == PAR_ZERO) begin
                    level_d = LVL_ZERO;
                end else if (tick_q) begin
                    level_d = ({1'b0, level_q} <= step_s) ? LVL_ZERO : level_q - step_s[15:0];
                end
            end
            ST_RELEASE: begin
                if ((t1_q.release_t == PAR_ZERO) || (tick_q && ({1'b0, level_q} <= step_r))) begin
                    level_d = LVL_ZERO;
                    stage_d = ST_IDLE;
                end else if (tick_q) begin
                    level_d = level_q - step_r[15:0];
                end
            end
            default: begin
                stage_d = ST_IDLE;
                level_d = LVL_ZERO;
            end
        endcase
        if (retrig) begin
            level_d = start_lvl;
            dcnt_d = dly_load;
            if (t1_q.delay != PAR_ZERO) stage_d = ST_DELAY;
            else if (t0_q.attack != PAR_ZERO) stage_d = ST_ATTACK;
            else if (t0_q.sustain >= PAR_MAX) stage_d = ST_SUST;
            else stage_d = ST_DECAY;
        end else if (pedal_hold_ev) begin
            if (quick && (stage_q != ST_IDLE)) begin
                stage_d = ST_RELEASE;
            end else if (!frun && (stage_q == ST_ATTACK)) begin
                stage_d = ST_SUST;
            end else if (!frun && (stage_q == ST_DELAY)) begin
                stage_d = ST_RELEASE;
                level_d = LVL_ZERO;
            end
        end else if (rel_ev && !frun && (stage_q != ST_IDLE)) begin
            stage_d = ST_RELEASE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_q <= ST_IDLE;
            level_q <= LVL_ZERO;
            dcnt_q <= 13'h0000;
            tcnt_q <= 16'h0000;
            tick_q <= 1'b0;
            held_q <= 1'b0;
            gate_q <= 1'b0;
            vel_q <= VEL_FULL;
            key_q <= KEY_CENTER;
        end else if (ce) begin
            stage_q <= stage_d;
            level_q <= level_d;
            dcnt_q <= dcnt_d;
            tick_q <= tcnt_q == 16'(TICK_CYCLES - 1);
            tcnt_q <= (tcnt_q == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tcnt_q + 16'h0001;
            held_q <= held_d;
            gate_q <= gate_d;
            if (note.on) begin
                vel_q <= note.vel;
                key_q <= note.key;
            end
        end
    end

    // Output scaling; the constant divide is wide but keeps the law exact at 00 and 99
    wire [6:0] vmod = clamp99(t1_q.velmod);
    wire [13:0] vel_loss = 14'({7'h00, vmod} * {7'h00, VEL_FULL - vel_q});
    wire [13:0] vel_factor = VEL_SPAN - vel_loss;
    wire [36:0] prod = {21'h000000, level_q} * {30'h00000000, clamp99(t1_q.level)}
        * {23'h000000, vel_factor};
    wire [36:0] scaled = prod / OUT_DIV;
    wire active = (ctl_q.depth != 8'h00) || ctl_q.mod_src;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mod_level <= LVL_ZERO;
        end else if (ce) begin
            mod_level <= active ? scaled[15:0] : LVL_ZERO;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_start_quick;
        ce && retrig && (t1_q.delay == PAR_ZERO) && (t0_q.attack == PAR_ZERO);
    endsequence
    sequence s_gate_off;
        ce && !ctl_q.mod_src && (ctl_q.depth == 8'h00);
    endsequence
    sequence s_release_tick;
        ce && (stage_q == ST_RELEASE) && !note.on && tick_q && (level_q != LVL_ZERO);
    endsequence

    a_attack_instant: assert property (s_start_quick |=> level_q == LVL_MAX)
        else $error("Zero delay and attack did not reach full level");
    a_start_attack: assert property (ce && retrig && (t1_q.delay == PAR_ZERO)
        && (t0_q.attack != PAR_ZERO) |=> stage_q == ST_ATTACK)
        else $error("Zero delay did not start attack at once");
    a_decay_bypass: assert property (ce && no_ovr && (stage_q == ST_ATTACK)
        && (stage_d != ST_ATTACK) && (t0_q.sustain == PAR_MAX) |=> stage_q == ST_SUST)
        else $error("Full sustain did not bypass decay");
    a_sdecay_zero: assert property (ce && no_ovr && (stage_q == ST_SUST) && gate_d
        && (t0_q.sdecay == PAR_ZERO) |=> level_q == LVL_ZERO)
        else $error("Zero sustain decay did not drop level");
    a_release_falls: assert property (s_release_tick |=> level_q < $past(level_q))
        else $error("Release level did not fall on tick");
    a_hold_waits: assert property (ce && (stage_q == ST_DELAY) && hold_dly && gate_d
        && !retrig |=> stage_q == ST_DELAY)
        else $error("Delay hold left before key release");
    a_normal_keep: assert property (ce && note.on && !ctl_q.trig_reset
        && (stage_q == ST_ATTACK) |=> stage_q != ST_DELAY)
        else $error("Normal mode restarted a running envelope");
    a_normal_release: assert property (ce && rel_ev && !frun
        && (stage_q != ST_IDLE) |=> stage_q == ST_RELEASE)
        else $error("Normal mode note-off did not enter release");
    a_reset_restart: assert property (ce && note.on && ctl_q.trig_reset
        && (t1_q.delay != PAR_ZERO) |=> (stage_q == ST_DELAY) && (level_q == LVL_ZERO))
        else $error("Reset mode did not restart from the beginning");
    a_pedal_quick: assert property (ce && pedal_hold_ev && quick && !hold_dly
        && (stage_q != ST_IDLE) |=> stage_q == ST_RELEASE)
        else $error("Pedal note-off did not release instant envelope");
    a_pedal_attack: assert property (ce && pedal_hold_ev && !frun && !quick
        && (stage_q == ST_ATTACK) |=> stage_q == ST_SUST)
        else $error("Pedal note-off in attack did not jump to sustain");
    a_depth_gate: assert property (s_gate_off |=> mod_level == LVL_ZERO)
        else $error("Output active with zero depth and no routing");
endmodule

// ---- feg_key_src.sv ----
/*
 Keyboard event source: note-on and note-off pulses, velocity, key and pedal.
 Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ns
module feg_key_src
    import feg_pkg::*;
(
    input wire logic aclk,
    output feg_note_t note,
    output logic pedal
);
    initial begin
        note = '0;
        pedal = 1'b0;
    end
    // Key and velocity mean nothing without on, so they never linger
    task automatic key_on(input logic [6:0] k, input logic [6:0] v, input logic lg);
        note <= '{on: 1'b1, off: 1'b0, legato: lg, vel: v, key: k};
        @(posedge aclk);
        note <= '{on: 1'b0, off: 1'b0, legato: 1'b0, vel: ~v, key: ~k};
    endtask
    task automatic key_off();
        note.off <= 1'b1;
        @(posedge aclk);
        note.off <= 1'b0;
    endtask
    task automatic set_pedal(input logic p);
        pedal <= p;
    endtask
endmodule

// ---- feg_tone_contour_gen_tb.sv ----
/*
 Self-checking bench for the tone contour generator with an integer output model.
 Assumes a four-cycle envelope tick and an AXI4-Lite slave that may stall.
*/
`timescale 1ns/1ns
module feg_tone_contour_gen_tb;
    import feg_pkg::*;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pedal;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, t1, ctl;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    feg_note_t note;
    logic [15:0] mod_level;
    int num_errors = 0;
    int cmp_count = 0;
    int vel, ls, vm, seed;
    feg_tone_contour_gen #(.TICK_CYCLES(4)) feg_tone_contour_gen_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .note(note), .pedal(pedal),
        .mod_level(mod_level));
    feg_key_src feg_key_src_inst (.aclk(aclk), .note(note), .pedal(pedal));
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic kon(input int k, input int l);
        feg_key_src_inst.key_on(7'(k), 7'(vel), 1'(l));
    endtask
    task automatic koff();
        feg_key_src_inst.key_off();
    endtask
    // The trailing idle edge keeps a following request from landing on the release
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, wd;
        int n;
        ad = 0;
        wd = 0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (bvalid === 1'b1 && ad && wd) begin
                r = bresp;
                n = 99;
            end
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
        if (n != 99) chk(32'h0, 32'h1);
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ad;
        int n;
        ad = 0;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (rvalid === 1'b1 && ad) begin
                d = rdata;
                r = rresp;
                n = 99;
            end
            if (!ad && arready === 1'b1) begin
                ad = 1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
        if (n != 99) chk(32'h0, 32'h1);
        @(posedge aclk);
    endtask
    task automatic st(input int es, input int el);
        axr(ADDR_STAT, rd, rs);
        if (es >= 0) chk({26'h0, rd[5:0]}, es);
        if (el >= 0) chk({16'h0, rd[31:16]}, el);
    endtask
    task automatic cfg(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
        axw(ADDR_TIME0, a, rs);
        axw(ADDR_TIME1, b, rs);
        axw(ADDR_CTRL, c, rs);
        t1 = b;
        ctl = c;
    endtask
    function automatic longint eo(input longint l);
        longint lv, vv;
        lv = t1[22:16];
        vv = t1[30:24];
        if (ctl[15:8] == 0 && !ctl[5]) return 0;
        return l * lv * (longint'(VEL_SPAN) - vv * (127 - vel)) / longint'(OUT_DIV);
    endfunction
    task automatic close_out();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(100 * 40000);
        num_errors++;
        close_out();
    end
    initial begin
        seed = $urandom(44);
        {ce, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {awaddr, araddr, wdata, wstrb, vel} = '0;
        cyc(5);
        aresetn <= 1'b1;
        cyc(1);
        axr(ADDR_TIME0, rd, rs);
        chk(rd, TIME0_RST);
        axr(ADDR_TIME1, rd, rs);
        chk(rd, TIME1_RST);
        axr(ADDR_CTRL, rd, rs);
        chk(rd, CTRL_RST);
        axr(8'h10, rd, rs);
        chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
        axw(8'h10, 32'hffffffff, rs);
        chk(rs, RESP_SLVERR);
        axw(ADDR_STAT, 32'hffffffff, rs);
        chk(rs, RESP_OKAY);
        axw(ADDR_TIME0, 32'hffffffff, rs);
        axr(ADDR_TIME0, rd, rs);
        chk(rd, TIME_MASK);
        st(ST_IDLE, 0);
        // Depth and routing off, routed, level zero, random level
        for (int i = 0; i < 4; i++) begin
            vel = $urandom_range(127, 1);
            ls = (i == 0) ? 99 : (i == 2) ? 0 : $urandom_range(98, 1);
            vm = (i % 2) ? 99 : 0;
            // Release 16 can be watched falling yet ends well inside 60 cycles
            cfg(32'h63630000, {1'b0, 7'(vm), 1'b0, 7'(ls), 16'h0010},
                (i == 0) ? 32'h0 : (i == 1) ? 32'h20 : 32'h100);
            kon(60 + i, 0);
            cyc(3);
            st(ST_SUST, 65340);
            chk(mod_level, eo(65340));
            koff();
            cyc(2);
            st(ST_RELEASE, -1);
            cyc(60);
            st(-1, 0);
            chk(mod_level, 0);
        end
        cfg(32'h00630000, 32'h00630000, 32'h100);
        kon(60, 0);
        cyc(3);
        st(-1, 0);
        koff();
        cyc(5);
        axw(ADDR_TIME0, 32'h63323000, rs);
        kon(60, 0);
        cyc(1);
        st(ST_DECAY, -1);
        cyc(100);
        st(ST_SUST, 33000);
        koff();
        cyc(60);
        // Two octaves up the decay step doubles, so sustain comes twice as soon
        axw(ADDR_CTRL, 32'h104, rs);
        kon(84, 0);
        cyc(30);
        st(ST_SUST, 33000);
        koff();
        cyc(60);
        cfg(32'h63630000, 32'h00630100, 32'h100);
        kon(60, 0);
        cyc(150);
        st(ST_DELAY, 0);
        cyc(110);
        st(ST_SUST, 65340);
        // Every trigger mode, poly then mono legato, given a new note in sustain; only the reset modes retrigger
        for (int m = 0; m < 8; m++) begin
            axw(ADDR_CTRL, 32'h100 | (m & 3) | ((m & 4) << 2), rs);
            kon(62, m / 4);
            cyc(3);
            st(m[1] ? ST_DELAY : ST_SUST, -1);
            cyc(270);
        end
        koff();
        cyc(60);
        cfg(32'h63630063, 32'h00630000, 32'h101);
        kon(60, 0);
        cyc(5);
        koff();
        cyc(5);
        st(ST_ATTACK, -1);
        axw(ADDR_CTRL, 32'h102, rs);
        kon(60, 0);
        cyc(5);
        koff();
        // Release 0 leaves the release stage after one edge, so the read goes out at once
        st(ST_RELEASE, -1);
        cyc(60);
        cfg(32'h63630000, 32'h00630000, 32'h108);
        feg_key_src_inst.set_pedal(1'b1);
        kon(60, 0);
        cyc(5);
        koff();
        st(ST_RELEASE, -1);
        cyc(60);
        axw(ADDR_TIME0, 32'h63630063, rs);
        kon(60, 0);
        cyc(5);
        koff();
        cyc(2);
        st(ST_SUST, -1);
        feg_key_src_inst.set_pedal(1'b0);
        cyc(1);
        st(ST_RELEASE, -1);
        cyc(60);
        axw(ADDR_CTRL, 32'h100, rs);
        feg_key_src_inst.set_pedal(1'b1);
        kon(60, 0);
        cyc(5);
        koff();
        st(ST_RELEASE, -1);
        cyc(60);
        cfg(32'h63630000, 32'h00630100, 32'h108);
        kon(60, 0);
        cyc(5);
        koff();
        cyc(260);
        st(ST_IDLE, 0);
        feg_key_src_inst.set_pedal(1'b0);
        // Held delay outlasts what a plain count of 100 would give
        cfg(32'h63630000, 32'h00636463, 32'h102);
        kon(60, 0);
        cyc(21000);
        st(ST_DELAY, 0);
        koff();
        cyc(5);
        st(ST_RELEASE, -1);
        chk(rd[31:16] > 16'd60000, 1);
        close_out();
    end
endmodule
